// [verilog/cpucu_defs.svh]
// constants of the flow-and-interrupt control unit
`ifndef CPUCU_DEFS_SVH
`define CPUCU_DEFS_SVH
// opcode prefixes
`define CPUCU_OP_FLOW 4'hB
`define CPUCU_OP_BTYPE 4'hF
// flow operation selectors in bits 11:8
`define CPUCU_SEL_JMP 4'h0
`define CPUCU_SEL_JNV 4'h8
`define CPUCU_SEL_CALL 4'h9
`define CPUCU_SEL_RTS 4'hA
`define CPUCU_SEL_RTI 4'hB
`define CPUCU_SEL_CLI 4'hC
`define CPUCU_SEL_STI 4'hD
// program counter vectors
`define CPUCU_PC_RESET 8'h00
`define CPUCU_INT_VECTOR 8'h01
// flag vector bit positions {z,c,n,v}
`define CPUCU_FLG_Z 3
`define CPUCU_FLG_C 2
`define CPUCU_FLG_N 1
`define CPUCU_FLG_V 0
// debug register offsets
`define CPUCU_REG_FLAGS 2'h0
`define CPUCU_REG_PC 2'h1
`define CPUCU_REG_STATUS 2'h2
// debug flags register fields
`define CPUCU_DBG_IE 4
`define CPUCU_DBG_IH 5
`endif

// [verilog/cpucu_pkg.sv]
// types of the flow-and-interrupt control unit
package cpucu_pkg;
   // controller states
   typedef enum logic [3:0]
   {
      FETCH_STATE = 4'h0,
      DECODE_STATE = 4'h1,
      BREAK_STATE = 4'h2,
      INT_REQ_STATE = 4'h3,
      EXEC_LOAD_STATE = 4'h4,
      EXEC_STORE_STATE = 4'h5,
      EXEC_MOVE_STATE = 4'h6,
      EXEC_ARITH_STATE = 4'h7,
      EXEC_LOGIC_STATE = 4'h8,
      EXEC_SHIFT_STATE = 4'h9,
      EXEC_FLOW_STATE = 4'hA,
      EXEC_IDLE_STATE = 4'hB
   } cpucu_state_type;
endpackage

// [verilog/cpucu_core.sv]
// control unit: fetch, flow decode, return stack and interrupt entry
`timescale 1ns/1ps
`include "cpucu_defs.svh"

////////////////////////////////////////////////////////////////////////
// Contract
// - shift controls: direction, rotate, fill, arithmetic
// - prefix 1011 absolute flow, low byte target
// - prefix 1111, sub 1011, register target
// - bits 11:8 select flow operation
// - eight flag conditions; failed keeps counter
// - flow leaves flags, interrupt return restores
// - call pushes next address, loads target
// - return pops saved address, flags untouched
// - disable clears, enable sets enable bit
// - interrupt taken after instruction, request, enable
// - single active-high request, no vectoring
// - entry pushes state, vector 0x01, disables
// - in-handler flag visible only to debug
// - interrupt return restores counter and flags
// - sixteen entry, fourteen bit return stack
// - four-bit pointer, read at pointer minus one
// - instruction register captures fetched word
// - counter reset, vector, target, return, increment
// - break in fetch halts until continue
// - one execute state per instruction group
// - vector loaded in interrupt request state
// - rising edge storage, reset to initial
module cpucu_core
#(
   parameter int STACK_DEPTH = 16
)
(
   input logic mclk,
   input logic rst,
   input logic [15:0] pmemData,
   input logic [7:0] regYData,
   input logic [3:0] aluFlags,
   input logic aluFlagsWe,
   input logic irq,
   input logic dbgBreak,
   input logic dbgContinue,
   input logic [1:0] dbgAddr,
   input logic dbgWr,
   input logic dbgRd,
   input logic [7:0] dbgWdata,
   output logic [7:0] dbgRdata_ff,
   output logic [7:0] progCounter_ff,
   output logic [15:0] instrReg_ff,
   output cpucu_pkg::cpucu_state_type state_ff,
   output logic [3:0] flags_ff,
   output logic intEnableBit_ff,
   output logic inHandler_ff,
   output logic [3:0] stackPtr_ff,
   output logic shiftRight_ff,
   output logic shiftRotate_ff,
   output logic fillFromCarry_ff,
   output logic shiftArith_ff
);

////////////////////////////////////////////////////////////////////////
// next values
cpucu_pkg::cpucu_state_type nxt_state;
logic [7:0] nxt_progCounter;
logic [15:0] nxt_instrReg;
logic [3:0] nxt_flags;
logic nxt_intEnableBit;
logic nxt_inHandler;
logic [3:0] nxt_stackPtr;
logic [7:0] nxt_dbgRdata;
logic [3:0] nxt_shiftCtl;
// stack write port
logic stackWe;
logic [13:0] stackWd;
// return stack storage
logic [13:0] stackMem [STACK_DEPTH];
// entry on top, read at pointer minus one
logic [13:0] stackTop;
// flow decode helpers
logic isAbs;
logic isInd;
logic [3:0] flowSel;
logic lowZero;
logic [7:0] flowTarget;

////////////////////////////////////////////////////////////////////////
// flag condition of a conditional jump
function automatic logic condMet(input logic [3:0] sel,
                                 input logic [3:0] flg);
   logic res;
   res = 1'b0;
   case (sel)
      4'h0: res = 1'b1; // unconditional jump
      4'h1: res = flg[`CPUCU_FLG_Z];
      4'h2: res = !flg[`CPUCU_FLG_Z];
      4'h3: res = flg[`CPUCU_FLG_C];
      4'h4: res = !flg[`CPUCU_FLG_C];
      4'h5: res = flg[`CPUCU_FLG_N];
      4'h6: res = !flg[`CPUCU_FLG_N];
      4'h7: res = flg[`CPUCU_FLG_V];
      4'h8: res = !flg[`CPUCU_FLG_V];
      default: res = 1'b0;
   endcase
   return res;
endfunction

// execute group of an instruction word
function automatic cpucu_pkg::cpucu_state_type grpOf(
   input logic [15:0] ins);
   logic [3:0] op;
   cpucu_pkg::cpucu_state_type st;
   op = (ins[15:12] == `CPUCU_OP_BTYPE) ? ins[7:4] : ins[15:12];
   st = cpucu_pkg::EXEC_IDLE_STATE;
   case (op)
      4'h0, 4'h1, 4'h2, 4'h3, 4'hA:
         st = cpucu_pkg::EXEC_ARITH_STATE;
      4'h4, 4'h5, 4'h6, 4'h8:
         st = cpucu_pkg::EXEC_LOGIC_STATE;
      // swap for the short form, shift for the long form
      4'h7:
         st = (ins[15:12] == `CPUCU_OP_BTYPE) ?
              cpucu_pkg::EXEC_SHIFT_STATE :
              cpucu_pkg::EXEC_LOGIC_STATE;
      4'h9: st = cpucu_pkg::EXEC_STORE_STATE;
      4'hB: st = cpucu_pkg::EXEC_FLOW_STATE;
      4'hC: st = cpucu_pkg::EXEC_MOVE_STATE;
      4'hD: st = cpucu_pkg::EXEC_LOAD_STATE;
      default: st = cpucu_pkg::EXEC_IDLE_STATE;
   endcase
   return st;
endfunction

////////////////////////////////////////////////////////////////////////
// flow field decode
assign isAbs = (instrReg_ff[15:12] == `CPUCU_OP_FLOW);
assign isInd = (instrReg_ff[15:12] == `CPUCU_OP_BTYPE);
// destination field used as operation selector
assign flowSel = instrReg_ff[11:8];
assign lowZero = (instrReg_ff[7:0] == 8'h00);
// target from the low byte or from the named register
assign flowTarget = isAbs ? instrReg_ff[7:0] : regYData;
// top of stack, pointer minus one
assign stackTop = stackMem[stackPtr_ff - 4'h1];

////////////////////////////////////////////////////////////////////////
// next-state and datapath-control computation
always_comb
begin
   nxt_state = state_ff;
   nxt_progCounter = progCounter_ff;
   nxt_instrReg = instrReg_ff;
   nxt_flags = flags_ff;
   nxt_intEnableBit = intEnableBit_ff;
   nxt_inHandler = inHandler_ff;
   nxt_stackPtr = stackPtr_ff;
   nxt_shiftCtl = {shiftArith_ff, fillFromCarry_ff,
                   shiftRotate_ff, shiftRight_ff};
   nxt_dbgRdata = 8'h00;
   stackWe = 1'b0;
   stackWd = 14'h0000;
   case (state_ff)
      // fetch: capture word and step counter, or halt
      cpucu_pkg::FETCH_STATE:
      begin
         if (dbgBreak)
         begin
            nxt_state = cpucu_pkg::BREAK_STATE;
         end
         else
         begin
            nxt_instrReg = pmemData;
            nxt_progCounter = progCounter_ff + 8'h01;
            // shift and rotate controls from the low bits
            nxt_shiftCtl = pmemData[3:0];
            nxt_state = cpucu_pkg::DECODE_STATE;
         end
      end
      // halted until the debug side lets go
      cpucu_pkg::BREAK_STATE:
      begin
         nxt_state = dbgContinue ? cpucu_pkg::FETCH_STATE :
                     cpucu_pkg::BREAK_STATE;
      end
      // pick the execute state of the group
      cpucu_pkg::DECODE_STATE:
      begin
         nxt_state = grpOf(instrReg_ff);
      end
      // interrupt entry: save context, jump to vector
      cpucu_pkg::INT_REQ_STATE:
      begin
         stackWe = 1'b1;
         stackWd = {progCounter_ff, flags_ff, intEnableBit_ff, inHandler_ff};
         nxt_stackPtr = stackPtr_ff + 4'h1;
         nxt_progCounter = `CPUCU_INT_VECTOR;
         nxt_intEnableBit = 1'b0;
         nxt_inHandler = 1'b1;
         nxt_state = cpucu_pkg::FETCH_STATE;
      end
      // program control group
      cpucu_pkg::EXEC_FLOW_STATE:
      begin
         if (isAbs || isInd)
         begin
            if (flowSel <= `CPUCU_SEL_JNV)
            begin
               // jump always or on a flag; failed keeps counter
               if (condMet(flowSel, flags_ff))
               begin
                  nxt_progCounter = flowTarget;
               end
            end
            else if (flowSel == `CPUCU_SEL_CALL)
            begin
               // counter already points past the call
               stackWe = 1'b1;
               stackWd = {progCounter_ff, flags_ff,
                          intEnableBit_ff, inHandler_ff};
               nxt_stackPtr = stackPtr_ff + 4'h1;
               nxt_progCounter = flowTarget;
            end
            else if (isAbs && lowZero)
            begin
               if (flowSel == `CPUCU_SEL_RTS)
               begin
                  nxt_progCounter = stackTop[13:6];
                  nxt_stackPtr = stackPtr_ff - 4'h1;
               end
               else if (flowSel == `CPUCU_SEL_RTI)
               begin
                  // counter, flags and both bits together
                  nxt_progCounter = stackTop[13:6];
                  nxt_flags = stackTop[5:2];
                  nxt_intEnableBit = stackTop[1];
                  nxt_inHandler = stackTop[0];
                  nxt_stackPtr = stackPtr_ff - 4'h1;
               end
               else if (flowSel == `CPUCU_SEL_CLI || flowSel == `CPUCU_SEL_STI)
               begin
                  // selector bit 0 is the new enable value
                  nxt_intEnableBit = flowSel[0];
               end
            end
         end
         // interrupt only once the instruction is done
         nxt_state = (irq && nxt_intEnableBit) ?
                     cpucu_pkg::INT_REQ_STATE :
                     cpucu_pkg::FETCH_STATE;
      end
      // every other execute state
      default:
      begin
         // only arithmetic, logic and shift groups take new flags
         if (aluFlagsWe &&
             (state_ff == cpucu_pkg::EXEC_ARITH_STATE ||
              state_ff == cpucu_pkg::EXEC_LOGIC_STATE ||
              state_ff == cpucu_pkg::EXEC_SHIFT_STATE))
         begin
            nxt_flags = aluFlags;
         end
         nxt_state = (irq && intEnableBit_ff) ?
                     cpucu_pkg::INT_REQ_STATE :
                     cpucu_pkg::FETCH_STATE;
      end
   endcase
   // debug write of flags while halted
   if (dbgWr && dbgAddr == `CPUCU_REG_FLAGS &&
       state_ff == cpucu_pkg::BREAK_STATE)
   begin
      nxt_flags = dbgWdata[3:0];
      nxt_intEnableBit = dbgWdata[`CPUCU_DBG_IE];
   end
   // debug read, answered the next cycle
   if (dbgRd)
   begin
      if (dbgAddr == `CPUCU_REG_FLAGS)
      begin
         nxt_dbgRdata = {2'b00, inHandler_ff,
                         intEnableBit_ff, flags_ff};
      end
      else if (dbgAddr == `CPUCU_REG_PC)
      begin
         nxt_dbgRdata = progCounter_ff;
      end
      else if (dbgAddr == `CPUCU_REG_STATUS)
      begin
         nxt_dbgRdata = {stackPtr_ff, state_ff};
      end
   end
end

////////////////////////////////////////////////////////////////////////
// control registers, asynchronous reset
always_ff @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      state_ff <= cpucu_pkg::FETCH_STATE;
      progCounter_ff <= `CPUCU_PC_RESET;
      instrReg_ff <= 16'h0000;
      flags_ff <= 4'h0;
      intEnableBit_ff <= 1'b0;
      inHandler_ff <= 1'b0;
      stackPtr_ff <= 4'h0;
      dbgRdata_ff <= 8'h00;
      shiftRight_ff <= 1'b0;
      shiftRotate_ff <= 1'b0;
      fillFromCarry_ff <= 1'b0;
      shiftArith_ff <= 1'b0;
   end
   else
   begin
      state_ff <= nxt_state;
      progCounter_ff <= nxt_progCounter;
      instrReg_ff <= nxt_instrReg;
      flags_ff <= nxt_flags;
      intEnableBit_ff <= nxt_intEnableBit;
      inHandler_ff <= nxt_inHandler;
      stackPtr_ff <= nxt_stackPtr;
      dbgRdata_ff <= nxt_dbgRdata;
      shiftRight_ff <= nxt_shiftCtl[0];
      shiftRotate_ff <= nxt_shiftCtl[1];
      fillFromCarry_ff <= nxt_shiftCtl[2];
      shiftArith_ff <= nxt_shiftCtl[3];
   end
end

////////////////////////////////////////////////////////////////////////
// stack storage, no overflow check by design
always_ff @(posedge mclk)
begin
   if (stackWe)
   begin
      stackMem[stackPtr_ff] <= stackWd;
   end
end

////////////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge mclk);
endclocking
default disable iff (rst);

chk_fetch_pc_step: assert property (
   state_ff == cpucu_pkg::FETCH_STATE && !dbgBreak |=>
   progCounter_ff == $past(progCounter_ff) + 8'h01 &&
   state_ff == cpucu_pkg::DECODE_STATE)
   else $error("counter did not step in fetch");
chk_fetch_word_load: assert property (
   state_ff == cpucu_pkg::FETCH_STATE && !dbgBreak |=>
   instrReg_ff == $past(pmemData))
   else $error("instruction word not captured");
chk_break_hold_wait: assert property (
   state_ff == cpucu_pkg::FETCH_STATE && dbgBreak ##1
   !dbgContinue |=> state_ff == cpucu_pkg::BREAK_STATE)
   else $error("break state left without continue");
chk_int_entry_vector: assert property (
   state_ff == cpucu_pkg::INT_REQ_STATE |=>
   progCounter_ff == `CPUCU_INT_VECTOR && !intEnableBit_ff &&
   inHandler_ff && stackPtr_ff == $past(stackPtr_ff) + 4'h1)
   else $error("interrupt entry incomplete");
chk_int_after_exec: assert property (
   state_ff == cpucu_pkg::INT_REQ_STATE |->
   $past(irq) && $past(state_ff) != cpucu_pkg::FETCH_STATE &&
   $past(state_ff) != cpucu_pkg::DECODE_STATE &&
   $past(state_ff) != cpucu_pkg::BREAK_STATE)
   else $error("interrupt taken mid instruction");
chk_flow_flags_kept: assert property (
   state_ff == cpucu_pkg::EXEC_FLOW_STATE &&
   !(isAbs && flowSel == `CPUCU_SEL_RTI) && !dbgWr |=>
   flags_ff == $past(flags_ff))
   else $error("flow instruction changed flags");
chk_cond_fail_hold: assert property (
   state_ff == cpucu_pkg::EXEC_FLOW_STATE && isAbs &&
   flowSel != `CPUCU_SEL_JMP && flowSel <= `CPUCU_SEL_JNV &&
   !condMet(flowSel, flags_ff) |=>
   progCounter_ff == $past(progCounter_ff))
   else $error("failed condition moved counter");
chk_jump_target_load: assert property (
   state_ff == cpucu_pkg::EXEC_FLOW_STATE && isAbs &&
   flowSel == `CPUCU_SEL_JMP |=>
   progCounter_ff == $past(instrReg_ff[7:0]))
   else $error("jump target not loaded");
chk_call_push_addr: assert property (
   state_ff == cpucu_pkg::EXEC_FLOW_STATE && (isAbs || isInd) &&
   flowSel == `CPUCU_SEL_CALL |=>
   stackPtr_ff == $past(stackPtr_ff) + 4'h1 &&
   stackMem[$past(stackPtr_ff)][13:6] == $past(progCounter_ff))
   else $error("call did not push return address");
chk_int_disable_op: assert property (
   state_ff == cpucu_pkg::EXEC_FLOW_STATE && isAbs && lowZero &&
   flowSel == `CPUCU_SEL_CLI && !dbgWr |=> !intEnableBit_ff)
   else $error("disable did not clear enable");

endmodule

// [tb/cpucu_prog_mem_model.sv]
// program memory and register file model facing the control unit
`timescale 1ns/1ps
module cpucu_prog_mem_model
(
   input wire logic [7:0] addr,
   output logic [15:0] data,
   input wire logic [3:0] regIdx,
   output logic [7:0] regData
);
   // program words, unused places hold an unused opcode
   logic [15:0] mem [0:255];
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'hE000;
   end
   // asynchronous read of the word at the counter
   assign data = mem[addr];
   // register contents used as indirect target
   assign regData = {4'h5, regIdx};
endmodule

// [tb/tb.sv]
// self-checking bench of the flow-and-interrupt control unit
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] pmemData;
   logic [7:0] regYData;
   logic [3:0] aluFlags = 4'h0;
   logic aluFlagsWe = 1'b1;
   logic irq = 1'b0;
   logic dbgBreak = 1'b0;
   logic dbgContinue = 1'b0;
   logic [1:0] dbgAddr = 2'h0;
   logic dbgWr = 1'b0;
   logic dbgRd = 1'b0;
   logic [7:0] dbgWdata = 8'h00;
   logic [7:0] dbgRdata_ff;
   logic [7:0] progCounter_ff;
   logic [15:0] instrReg_ff;
   cpucu_pkg::cpucu_state_type state_ff;
   logic [3:0] flags_ff;
   logic intEnableBit_ff;
   logic inHandler_ff;
   logic [3:0] stackPtr_ff;
   logic shiftRight_ff;
   logic shiftRotate_ff;
   logic fillFromCarry_ff;
   logic shiftArith_ff;
   // bench state: expected counter and levels for the next fetch
   logic [7:0] progAddr;
   logic [7:0] retAddr;
   logic [3:0] nextFlags = 4'h0;
   logic irqLevel = 1'b0;
   logic brkLevel = 1'b0;
   logic taken;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////
   // clock, design and partner
   always #10 mclk = ~mclk;

   cpucu_core #(.STACK_DEPTH(16)) i_dut
   (
      .mclk(mclk), .rst(rst), .pmemData(pmemData), .regYData(regYData),
      .aluFlags(aluFlags), .aluFlagsWe(aluFlagsWe), .irq(irq),
      .dbgBreak(dbgBreak), .dbgContinue(dbgContinue), .dbgAddr(dbgAddr),
      .dbgWr(dbgWr), .dbgRd(dbgRd), .dbgWdata(dbgWdata),
      .dbgRdata_ff(dbgRdata_ff), .progCounter_ff(progCounter_ff),
      .instrReg_ff(instrReg_ff), .state_ff(state_ff),
      .flags_ff(flags_ff), .intEnableBit_ff(intEnableBit_ff),
      .inHandler_ff(inHandler_ff), .stackPtr_ff(stackPtr_ff),
      .shiftRight_ff(shiftRight_ff), .shiftRotate_ff(shiftRotate_ff),
      .fillFromCarry_ff(fillFromCarry_ff), .shiftArith_ff(shiftArith_ff)
   );

   cpucu_prog_mem_model i_pmem
   (
      .addr(progCounter_ff), .data(pmemData),
      .regIdx(instrReg_ff[3:0]), .regData(regYData)
   );

   ////////////////////////////////////////////////////////////////////
   // shared tasks
   // closing report and verdict
   task test_done;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one comparison, reported at once on a mismatch
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // place a word, run it to the next fetch, check word and counter
   task run(input logic [15:0] w, input logic [7:0] exp);
      int k;
      i_pmem.mem[progAddr] = w;
      @(posedge mclk);
      irq <= irqLevel;
      aluFlags <= nextFlags;
      dbgBreak <= brkLevel;
      k = 0;
      do
      begin
         @(posedge mclk);
         #1;
         k++;
      end
      while (state_ff !== cpucu_pkg::FETCH_STATE && k < 10);
      check(instrReg_ff, w);
      check({8'h00, progCounter_ff}, {8'h00, exp});
      progAddr = exp;
   endtask

   // debug port write, one strobe cycle
   task dbg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      dbgAddr <= a;
      dbgWdata <= d;
      dbgWr <= 1'b1;
      @(posedge mclk);
      dbgWr <= 1'b0;
   endtask

   // debug port read, data checked in the cycle after the strobe
   task dbg_rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge mclk);
      dbgAddr <= a;
      dbgRd <= 1'b1;
      @(posedge mclk);
      dbgRd <= 1'b0;
      #1;
      check({8'h00, dbgRdata_ff}, {8'h00, exp});
   endtask

   // reset and check the initial state
   task do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      #1;
      progAddr = 8'h00;
      check({8'h00, progCounter_ff}, 16'h0000);
      check({12'h000, state_ff}, 16'h0000);
      check({12'h000, stackPtr_ff}, 16'h0000);
      check({14'h0000, intEnableBit_ff, inHandler_ff}, 16'h0000);
   endtask

   // hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         test_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      do_reset();
      run(16'hB010, 8'h10);
      // jump selectors 0 to 8, absolute with one flag set, then indirect with the other
      for (int f = 0; f < 2; f++)
      begin
         nextFlags = f ? 4'h5 : 4'hA;
         run(16'h0000, progAddr + 8'h01);
         check({12'h000, flags_ff}, {12'h000, nextFlags});
         nextFlags = ~nextFlags;
         for (int s = 0; s < 9; s++)
         begin
            // flags now hold the inverse of nextFlags
            taken = (s == 0) || (nextFlags[3 - (s - 1) / 2] != s[0]);
            if (f == 0)
               run({4'hB, 4'(s), 8'h20 + 8'(s)},
                  taken ? 8'h20 + 8'(s) : progAddr + 8'h01);
            else
               run({4'hF, 4'(s), 8'hB3},
                  taken ? 8'h53 : progAddr + 8'h01);
         end
         check({12'h000, flags_ff}, {12'h000, ~nextFlags});
      end
      nextFlags = 4'h5;
      // indirect call and return
      retAddr = progAddr + 8'h01;
      run(16'hF9B3, 8'h53);
      check({12'h000, stackPtr_ff}, 16'h0001);
      run(16'hBA00, retAddr);
      // sixteen nested calls fill the stack exactly, then unwind
      retAddr = progAddr + 8'h01;
      for (int i = 0; i < 16; i++)
         run({8'hB9, 8'h80 + 8'(i)}, 8'h80 + 8'(i));
      check({12'h000, stackPtr_ff}, 16'h0000);
      for (int i = 15; i >= 0; i--)
         run(16'hBA00, (i == 0) ? retAddr : 8'h80 + 8'(i));
      check({12'h000, flags_ff}, {12'h000, nextFlags});
      // enable, take an interrupt, return from it
      run(16'hBD00, progAddr + 8'h01);
      check({15'h0000, intEnableBit_ff}, 16'h0001);
      nextFlags = 4'hC;
      run(16'h0000, progAddr + 8'h01);
      retAddr = progAddr + 8'h01;
      irqLevel = 1'b1;
      run(16'hE000, 8'h01);
      check({14'h0000, intEnableBit_ff, inHandler_ff}, 16'h0001);
      check({12'h000, stackPtr_ff}, 16'h0001);
      irqLevel = 1'b0;
      nextFlags = 4'h3;
      run(16'h0000, 8'h02);
      run(16'hBB00, retAddr);
      check({12'h000, flags_ff}, 16'h000C);
      check({14'h0000, intEnableBit_ff, inHandler_ff}, 16'h0002);
      // disabled: a request is not taken
      run(16'hBC00, progAddr + 8'h01);
      check({15'h0000, intEnableBit_ff}, 16'h0000);
      irqLevel = 1'b1;
      run(16'hE000, progAddr + 8'h01);
      irqLevel = 1'b0;
      // shift controls from the low bits
      nextFlags = 4'hC;
      run(16'hF073, progAddr + 8'h01);
      check({12'h000, shiftArith_ff, fillFromCarry_ff, shiftRotate_ff,
         shiftRight_ff}, 16'h0003);
      run(16'hF07C, progAddr + 8'h01);
      check({12'h000, shiftArith_ff, fillFromCarry_ff, shiftRotate_ff,
         shiftRight_ff}, 16'h000C);
      // break at the next fetch, debug access, continue
      brkLevel = 1'b1;
      run(16'hE000, progAddr + 8'h01);
      brkLevel = 1'b0;
      @(posedge mclk);
      dbgBreak <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      check({12'h000, state_ff}, 16'h0002);
      check({8'h00, progCounter_ff}, {8'h00, progAddr});
      dbg_wr(2'h0, 8'h06);
      dbg_wr(2'h1, 8'h77);
      dbg_rd(2'h0, 8'h06);
      dbg_rd(2'h1, progAddr);
      dbg_rd(2'h3, 8'h00);
      @(posedge mclk);
      dbgContinue <= 1'b1;
      @(posedge mclk);
      dbgContinue <= 1'b0;
      #1;
      check({12'h000, state_ff}, 16'h0000);
      nextFlags = 4'h6;
      run(16'hB030, 8'h30);
      check({12'h000, flags_ff}, 16'h0006);
      // data moving groups keep the flags, the logic group takes them
      nextFlags = 4'h9;
      run(16'hD012, progAddr + 8'h01);
      run(16'h9012, progAddr + 8'h01);
      run(16'hC012, progAddr + 8'h01);
      check({12'h000, flags_ff}, 16'h0006);
      run(16'h4012, progAddr + 8'h01);
      check({12'h000, flags_ff}, 16'h0009);
      // second reset in mid-run, then a first fetch from the reset vector
      run(16'hB940, 8'h40);
      do_reset();
      run(16'hB010, 8'h10);
      test_done;
   end
endmodule
